// ==== hdl/fbsc_pkg.sv ====
// How it works
// - Buffered mode keeps newest data, overwriting unread
// - Mailbox mode hands buffer ownership by handshake
// - Eight sync buffer units with direction, mode
// - Eight logical map units, bit-granular translation
// - 8K-byte process RAM shared by both sides
// - Ports run 100 Mbit/s full duplex only
// - Three network ports numbered 0, 1, 2
// - Auto-forwarder checks frames, passes to loop-back
// - Auto-forwarder timestamps every received frame
// - Loop-back skips ports without link or closed
// - Port 0 loop-back feeds the processing unit
// - Network main sets each port's loop state
// - Processing unit arbitrates network and local accesses
// - Sync buffer redirects and blocks by state
// - Sync buffer accesses raise events to the other side
// - Monitoring keeps error counters and watchdog
// - Restart auto-negotiation after receive errors if enabled
// - 64-bit distributed system time
// - Port link state reported to monitoring
// - Status drives run, error, link, activity LEDs
package fbsc_pkg;
    localparam int NPORT           = 3;
    localparam int NSB             = 8;
    localparam int NLM             = 8;
    localparam int RAM_BYTES       = 8192;
    localparam int AW              = 13;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int FRAME_MIN_BYTES = 64;
    localparam int WD_TIME_US      = 100;
    localparam int WD_CYCLES       = WD_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int ACT_TIME_US     = 20;
    localparam int ACT_CYCLES      = ACT_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [63:0] TIME_STEP = 64'(CLK_PERIOD_NS);

    typedef enum logic {
        FBSC_BUFFERED = 1'b0,
        FBSC_MAILBOX  = 1'b1
    } fbsc_mode_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic       err;
        logic [7:0] data;
    } fbsc_rx_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        logical;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } fbsc_req_t;

    typedef struct packed {
        logic          en;
        logic          net_writes;
        fbsc_mode_t    mode;
        logic [AW-1:0] start;
        logic [AW-1:0] len;
    } fbsc_sb_cfg_t;

    typedef struct packed {
        logic          en;
        logic          rd_en;
        logic          wr_en;
        logic [31:0]   lstart;
        logic [15:0]   len;
        logic [2:0]    sbit;
        logic [2:0]    ebit;
        logic [AW-1:0] pstart;
    } fbsc_lm_cfg_t;
endpackage

// ==== hdl/fbsc_core.sv ====
`timescale 1ns/1ps
module fbsc_core #(
    parameter int WD_CYCLES = fbsc_pkg::WD_CYCLES
) (
    input  logic                            clock,
    input  logic                            rst,
    input  logic                            link_clk,
    input  fbsc_pkg::fbsc_rx_t [2:0]        rx,
    output fbsc_pkg::fbsc_rx_t [2:0]        tx,
    input  logic [2:0]                      link_up,
    input  logic [2:0]                      loop_closed,
    input  fbsc_pkg::fbsc_req_t             net_req,
    output logic [7:0]                      net_rdata,
    output logic                            net_ack,
    output logic                            net_blocked,
    input  fbsc_pkg::fbsc_req_t             loc_req,
    output logic [7:0]                      loc_rdata,
    output logic                            loc_ack,
    output logic                            loc_blocked,
    input  fbsc_pkg::fbsc_sb_cfg_t [7:0]    sb_cfg,
    input  fbsc_pkg::fbsc_lm_cfg_t [7:0]    lm_cfg,
    output logic [7:0]                      sb_ev_net,
    output logic [7:0]                      sb_ev_loc,
    input  logic                            time_set,
    input  logic [63:0]                     time_load,
    output logic [63:0]                     sys_time,
    output logic [2:0][63:0]                rx_ts,
    output logic [2:0][7:0]                 err_cnt,
    output logic [2:0]                      link_state,
    output logic                            safe_state,
    input  logic                            enh_link_en,
    output logic [2:0]                      restart_an,
    output logic                            fpu_frame,
    input  logic                            app_run,
    output logic                            led_run,
    output logic                            led_err,
    output logic [2:0]                      led_link,
    output logic [2:0]                      led_act
);
    // Link domain
    logic [2:0]               lup_m_q, lup_l_q, lcl_m_q, lcl_l_q;
    logic [2:0]               sof_tg_q, done_tg_q, good_q;
    logic                     epu_tg_q;
    fbsc_pkg::fbsc_rx_t [2:0] d_q, tx_q;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lup_m_q <= 3'h0;
            lup_l_q <= 3'h0;
            lcl_m_q <= 3'h0;
            lcl_l_q <= 3'h0;
        end else begin
            lup_m_q <= link_up;
            lup_l_q <= lup_m_q;
            lcl_m_q <= loop_closed;
            lcl_l_q <= lcl_m_q;
        end
    end

    // A port forwards out only with link and an open loop
    wire [2:0] open_l = lup_l_q & ~lcl_l_q;

    genvar p;
    generate
        for (p = 0; p < fbsc_pkg::NPORT; p++) begin : g_af
            logic [10:0] cnt_q;
            logic        bad_q;
            wire  [10:0] cnt_d = rx[p].sof ? 11'h001 : (cnt_q == 11'h7FF ? cnt_q : cnt_q + 11'h001);
            wire         bad_d = (rx[p].sof ? 1'b0 : bad_q) | rx[p].err;
            wire         len_ok = cnt_d >= 11'(fbsc_pkg::FRAME_MIN_BYTES);
            always_ff @(posedge link_clk or posedge rst) begin
                if (rst) begin
                    cnt_q        <= 11'h000;
                    bad_q        <= 1'b0;
                    good_q[p]    <= 1'b0;
                    sof_tg_q[p]  <= 1'b0;
                    done_tg_q[p] <= 1'b0;
                end else if (rx[p].valid) begin
                    cnt_q <= cnt_d;
                    bad_q <= bad_d;
                    if (rx[p].sof) begin
                        sof_tg_q[p] <= ~sof_tg_q[p];
                    end
                    if (rx[p].eof) begin
                        good_q[p]    <= ~bad_d & len_ok;
                        done_tg_q[p] <= ~done_tg_q[p];
                    end
                end
            end
        end
    endgenerate

    // Processing unit sits between port 0 and port 1 on the ring
    wire fbsc_pkg::fbsc_rx_t epu_in = open_l[0] ? rx[0] : d_q[0];

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            d_q      <= '0;
            tx_q     <= '0;
            epu_tg_q <= 1'b0;
        end else begin
            d_q[1]   <= epu_in;
            d_q[2]   <= open_l[1] ? rx[1] : d_q[1];
            d_q[0]   <= open_l[2] ? rx[2] : d_q[2];
            tx_q[0]  <= open_l[0] ? d_q[0] : '0;
            tx_q[1]  <= open_l[1] ? d_q[1] : '0;
            tx_q[2]  <= open_l[2] ? d_q[2] : '0;
            if (epu_in.valid && epu_in.sof) begin
                epu_tg_q <= ~epu_tg_q;
            end
        end
    end
    assign tx = tx_q;

    // System domain crossings
    logic [6:0] tg_m_q, tg_s_q, tg_e_q;
    logic [5:0] lv_m_q, lv_s_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tg_m_q <= 7'h00;
            tg_s_q <= 7'h00;
            tg_e_q <= 7'h00;
            lv_m_q <= 6'h00;
            lv_s_q <= 6'h00;
        end else begin
            tg_m_q <= {epu_tg_q, done_tg_q, sof_tg_q};
            tg_s_q <= tg_m_q;
            tg_e_q <= tg_s_q;
            lv_m_q <= {good_q, link_up};
            lv_s_q <= lv_m_q;
        end
    end
    wire [6:0] tg_ev   = tg_s_q ^ tg_e_q;
    wire [2:0] sof_ev  = tg_ev[2:0];
    // Good flag and done toggle move on one link edge; a cycle's wait lets the flag land first
    logic [2:0] done_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_q <= 3'h0;
        end else begin
            done_q <= tg_ev[5:3];
        end
    end
    wire [2:0] done_ev = done_q;
    wire [2:0] good_s  = lv_s_q[5:3];
    wire [2:0] lup_s   = lv_s_q[2:0];
    wire [2:0] bad_ev  = done_ev & ~good_s;

    // Access arbitration
    wire                      net_go = net_req.req;
    wire                      loc_go = loc_req.req & ~net_req.req;
    wire fbsc_pkg::fbsc_req_t acc    = net_go ? net_req : loc_req;
    wire                      acc_go = net_go | loc_go;
    wire                      is_log = net_go & net_req.logical;

    logic                        lm_hit;
    logic [fbsc_pkg::AW-1:0]     lm_pa;
    logic [7:0]                  lm_mask;
    logic [31:0]                 lm_off;
    always_comb begin
        lm_hit  = 1'b0;
        lm_pa   = '0;
        lm_mask = 8'hFF;
        lm_off  = 32'h0;
        // Descending scan so the lowest numbered unit wins
        for (int i = fbsc_pkg::NLM - 1; i >= 0; i--) begin
            lm_off = acc.addr - lm_cfg[i].lstart;
            if (lm_cfg[i].en && acc.addr >= lm_cfg[i].lstart && lm_off < {16'h0, lm_cfg[i].len}
                && (acc.we ? lm_cfg[i].wr_en : lm_cfg[i].rd_en)) begin
                lm_hit  = 1'b1;
                lm_pa   = lm_cfg[i].pstart + lm_off[fbsc_pkg::AW-1:0];
                lm_mask = 8'hFF;
                if (lm_off == 32'h0) begin
                    lm_mask = lm_mask & 8'(8'hFF << lm_cfg[i].sbit);
                end
                if (lm_off == {16'h0, lm_cfg[i].len} - 32'h1) begin
                    lm_mask = lm_mask & 8'(8'hFF >> (3'h7 - lm_cfg[i].ebit));
                end
            end
        end
    end

    wire [fbsc_pkg::AW-1:0] pa     = is_log ? lm_pa : acc.addr[fbsc_pkg::AW-1:0];
    wire [7:0]              mask   = is_log ? lm_mask : 8'hFF;
    wire                    map_ok = ~is_log | lm_hit;

    // Sync buffer units
    logic [7:0]      sb_hit, full_q;
    logic [7:0][1:0] wbank_q, rbank_q, newest_q;
    logic            sb_any;
    logic [2:0]      sel;
    genvar s;
    generate
        for (s = 0; s < fbsc_pkg::NSB; s++) begin : g_sbh
            wire [fbsc_pkg::AW:0] top = {1'b0, sb_cfg[s].start} + {1'b0, sb_cfg[s].len};
            assign sb_hit[s] = sb_cfg[s].en && pa >= sb_cfg[s].start && {1'b0, pa} < top;
        end
    endgenerate
    always_comb begin
        sb_any = 1'b0;
        sel    = 3'h0;
        for (int i = fbsc_pkg::NSB - 1; i >= 0; i--) begin
            if (sb_hit[i]) begin
                sb_any = 1'b1;
                sel    = 3'(i);
            end
        end
    end

    wire fbsc_pkg::fbsc_sb_cfg_t c = sb_cfg[sel];
    wire [fbsc_pkg::AW-1:0] off    = pa - c.start;
    wire                    first  = off == '0;
    wire                    last   = off == c.len - 13'h0001;
    wire                    writer = net_go == c.net_writes;
    wire                    mbx    = c.mode == fbsc_pkg::FBSC_MAILBOX;
    wire                    mbx_bl = writer ? (full_q[sel] | ~acc.we) : (~full_q[sel] | acc.we);
    wire                    buf_bl = writer ? ~acc.we : acc.we;
    wire                    blk    = sb_any & (mbx ? mbx_bl : buf_bl);
    wire [1:0]              bank   = mbx ? 2'h0 : (writer ? wbank_q[sel] : (first ? newest_q[sel] : rbank_q[sel]));
    wire [fbsc_pkg::AW-1:0] boff   = bank == 2'h0 ? 13'h0000 : (bank == 2'h1 ? c.len : 13'(c.len << 1));
    wire [fbsc_pkg::AW-1:0] ram_a  = sb_any ? c.start + boff + off : pa;
    wire                    go     = acc_go & map_ok & ~blk;
    wire                    sb_end = go & sb_any & last;
    wire                    ram_wr = go & acc.we;

    generate
        for (s = 0; s < fbsc_pkg::NSB; s++) begin : g_sb
            wire me = sel == 3'(s) && sb_any && go;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    full_q[s]   <= 1'b0;
                    wbank_q[s]  <= 2'h0;
                    rbank_q[s]  <= 2'h1;
                    newest_q[s] <= 2'h1;
                end else if (me && mbx && last) begin
                    full_q[s] <= writer;
                end else if (me && !mbx) begin
                    if (writer && last) begin
                        newest_q[s] <= wbank_q[s];
                        wbank_q[s]  <= 2'h3 - wbank_q[s] - rbank_q[s];
                    end
                    if (!writer && first) begin
                        rbank_q[s] <= newest_q[s];
                    end
                end
            end
        end
    endgenerate

    // Process RAM and answers
    logic [7:0] ram [fbsc_pkg::RAM_BYTES];
    always_ff @(posedge clock) begin
        if (ram_wr) begin
            ram[ram_a] <= (ram[ram_a] & ~mask) | (acc.wdata & mask);
        end
    end

    logic [7:0]  rdata_q, ev_net_q, ev_loc_q;
    logic        net_ack_q, net_blk_q, loc_ack_q, loc_blk_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q   <= 8'h00;
            net_ack_q <= 1'b0;
            net_blk_q <= 1'b0;
            loc_ack_q <= 1'b0;
            loc_blk_q <= 1'b0;
            ev_net_q  <= 8'h00;
            ev_loc_q  <= 8'h00;
        end else begin
            rdata_q   <= ram[ram_a];
            net_ack_q <= net_go;
            net_blk_q <= net_go & ~go;
            loc_ack_q <= loc_go;
            loc_blk_q <= loc_go & ~go;
            // The party that did not make the access is told
            ev_net_q  <= sb_end & loc_go ? 8'(8'h01 << sel) : 8'h00;
            ev_loc_q  <= sb_end & net_go ? 8'(8'h01 << sel) : 8'h00;
        end
    end
    assign net_rdata   = rdata_q;
    assign loc_rdata   = rdata_q;
    assign net_ack     = net_ack_q;
    assign net_blocked = net_blk_q;
    assign loc_ack     = loc_ack_q;
    assign loc_blocked = loc_blk_q;
    assign sb_ev_net   = ev_net_q;
    assign sb_ev_loc   = ev_loc_q;

    // Time, monitoring, status
    logic [63:0]      time_q;
    logic [2:0][63:0] ts_q;
    logic [2:0][7:0]  ecnt_q;
    logic [2:0][10:0] act_q;
    logic [31:0]      wd_q;
    logic [2:0]       rst_an_q, lact_q;
    logic             safe_q, fpu_q, run_q;
    wire              wd_kick = go & net_go & acc.we & sb_any;
    wire  [31:0]      wd_d    = wd_kick ? 32'h0 : (wd_q < 32'(WD_CYCLES) ? wd_q + 32'h1 : wd_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            time_q   <= 64'h0;
            ts_q     <= '0;
            ecnt_q   <= '0;
            act_q    <= '0;
            wd_q     <= 32'h0;
            rst_an_q <= 3'h0;
            lact_q   <= 3'h0;
            safe_q   <= 1'b0;
            fpu_q    <= 1'b0;
            run_q    <= 1'b0;
        end else begin
            time_q   <= time_set ? time_load : time_q + fbsc_pkg::TIME_STEP;
            wd_q     <= wd_d;
            safe_q   <= wd_d >= 32'(WD_CYCLES);
            rst_an_q <= bad_ev & {3{enh_link_en}};
            fpu_q    <= tg_ev[6];
            run_q    <= app_run;
            for (int i = 0; i < fbsc_pkg::NPORT; i++) begin
                if (sof_ev[i]) begin
                    ts_q[i] <= time_q;
                end
                if (bad_ev[i] && ecnt_q[i] != 8'hFF) begin
                    ecnt_q[i] <= ecnt_q[i] + 8'h01;
                end
                if (sof_ev[i]) begin
                    act_q[i] <= 11'(fbsc_pkg::ACT_CYCLES);
                end else if (act_q[i] != 11'h000) begin
                    act_q[i] <= act_q[i] - 11'h001;
                end
                lact_q[i] <= lup_s[i] & (act_q[i] != 11'h000);
            end
        end
    end
    assign sys_time   = time_q;
    assign rx_ts      = ts_q;
    assign err_cnt    = ecnt_q;
    assign link_state = lv_s_q[2:0];
    assign safe_state = safe_q;
    assign restart_an = rst_an_q;
    assign fpu_frame  = fpu_q;
    assign led_run    = run_q;
    assign led_err    = safe_q;
    assign led_link   = lv_s_q[2:0];
    assign led_act    = lact_q;

    // Assertions
    ram_write_a: assert property (@(posedge clock) disable iff (rst)
        ram_wr && mask == 8'hFF |=> ram[$past(ram_a)] == $past(acc.wdata))
        else $error("process ram write lost");
    net_prio_a: assert property (@(posedge clock) disable iff (rst)
        net_req.req && loc_req.req |=> net_ack && !loc_ack)
        else $error("local access not held off");
    mbx_block_a: assert property (@(posedge clock) disable iff (rst)
        acc_go && sb_any && mbx && writer && full_q[sel] |=> (net_blocked || loc_blocked))
        else $error("write into full mailbox accepted");
    buf_newest_a: assert property (@(posedge clock) disable iff (rst)
        sb_end && !mbx && writer |=> newest_q[$past(sel)] == $past(wbank_q[sel]))
        else $error("newest buffer not updated");
    sb_event_a: assert property (@(posedge clock) disable iff (rst)
        sb_end && net_go |=> sb_ev_loc == 8'($past(8'h01 << sel)) && sb_ev_net == 8'h00)
        else $error("missing local event");
    time_inc_a: assert property (@(posedge clock) disable iff (rst)
        !time_set |=> sys_time == $past(sys_time) + fbsc_pkg::TIME_STEP)
        else $error("system time step wrong");
    ts_capture_a: assert property (@(posedge clock) disable iff (rst)
        sof_ev[0] |=> rx_ts[0] == $past(sys_time))
        else $error("timestamp not captured");
    err_count_a: assert property (@(posedge clock) disable iff (rst)
        bad_ev[0] && err_cnt[0] != 8'hFF |=> err_cnt[0] == $past(err_cnt[0]) + 8'h01)
        else $error("error counter missed");
    restart_an_a: assert property (@(posedge clock) disable iff (rst)
        restart_an[0] |-> $past(bad_ev[0]) && $past(enh_link_en))
        else $error("spurious negotiation restart");
    wd_safe_a: assert property (@(posedge clock) disable iff (rst)
        wd_kick |=> !safe_state)
        else $error("safe state despite fresh write");
    loop_skip_a: assert property (@(posedge link_clk) disable iff (rst)
        !open_l[1] |=> d_q[2] == $past(d_q[1]) && tx[1] == '0)
        else $error("closed port not bypassed");
    port0_epu_a: assert property (@(posedge link_clk) disable iff (rst)
        open_l[0] |=> d_q[1] == $past(rx[0]))
        else $error("port 0 frame not sent to processing unit");
endmodule

// ==== verif/fbsc_link_src.sv ====
`timescale 1ns/1ps
// Frame source on the link side: one byte per link cycle
module fbsc_link_src (
    input  logic                     link_clk,
    input  logic                     rst,
    input  logic                     go,
    input  logic [1:0]               port,
    input  logic [7:0]               len,
    output fbsc_pkg::fbsc_rx_t [2:0] rx,
    output logic                     busy
);
    logic [7:0] idx_q;
    logic [7:0] junk_q;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            idx_q  <= 8'h00;
            busy   <= 1'b0;
            junk_q <= 8'hA5;
        end else begin
            // Idle data toggles so a stale byte never looks valid
            junk_q <= ~junk_q;
            if (!busy && go) begin
                busy  <= 1'b1;
                idx_q <= 8'h00;
            end else if (busy) begin
                idx_q <= idx_q + 8'h01;
                busy  <= (idx_q != len - 8'h01);
            end
        end
    end
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            rx[p].valid = busy && (port == p[1:0]);
            rx[p].sof   = rx[p].valid && (idx_q == 8'h00);
            rx[p].eof   = rx[p].valid && (idx_q == len - 8'h01);
            rx[p].err   = 1'b0;
            rx[p].data  = rx[p].valid ? idx_q + 8'h10 : junk_q;
        end
    end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rst = 1, link_clk = 0, go = 0, busy;
    fbsc_pkg::fbsc_rx_t [2:0] rx, tx;
    logic [2:0] link_up = 3'h7, loop_closed = 3'h0, restart_an, link_state, led_link, led_act;
    fbsc_pkg::fbsc_req_t net_req = '0, loc_req = '0;
    logic [7:0] net_rdata, loc_rdata, sb_ev_net, sb_ev_loc, ev_l = 8'h00, ev_n = 8'h00;
    logic net_ack, net_blocked, loc_ack, loc_blocked, safe_state, fpu_frame, led_run, led_err;
    logic time_set = 0, enh_link_en = 0, app_run = 0;
    fbsc_pkg::fbsc_sb_cfg_t [7:0] sb_cfg = '0;
    fbsc_pkg::fbsc_lm_cfg_t [7:0] lm_cfg = '0;
    logic [63:0] time_load = 64'h0, sys_time, t0;
    logic [2:0][63:0] rx_ts;
    logic [2:0][7:0] err_cnt;
    logic [1:0] port = 2'h0;
    logic [7:0] len = 8'h40;
    int err_total = 0, checked = 0, tx1_n = 0, tx2_n = 0, fpu_n = 0, an_n = 0;

    always #5 clock = ~clock;
    // Odd offset keeps link edges clear of system edges
    initial begin
        #0.7;
        forever #3 link_clk = ~link_clk;
    end

    fbsc_core #(.WD_CYCLES(50)) i_dut (.clock, .rst, .link_clk, .rx, .tx, .link_up, .loop_closed,
        .net_req, .net_rdata, .net_ack, .net_blocked, .loc_req, .loc_rdata, .loc_ack, .loc_blocked,
        .sb_cfg, .lm_cfg, .sb_ev_net, .sb_ev_loc, .time_set, .time_load, .sys_time, .rx_ts, .err_cnt,
        .link_state, .safe_state, .enh_link_en, .restart_an, .fpu_frame, .app_run, .led_run, .led_err,
        .led_link, .led_act);
    fbsc_link_src i_src (.link_clk, .rst, .go, .port, .len, .rx, .busy);

    always @(posedge link_clk) begin
        if (tx[1].valid === 1'b1) tx1_n++;
        if (tx[2].valid === 1'b1) tx2_n++;
    end
    always @(posedge clock) begin
        if (fpu_frame === 1'b1) fpu_n++;
        if (restart_an[0] === 1'b1) an_n++;
        ev_l = ev_l | sb_ev_loc;
        ev_n = ev_n | sb_ev_net;
    end

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One byte access; the answer stands for a single cycle
    task automatic acc(input bit lo, input bit we, input bit lg, input logic [31:0] a,
                       input logic [7:0] d, input logic [7:0] er, input bit eb);
        fbsc_pkg::fbsc_req_t r;
        r = '{req: 1'b1, we: we, logical: lg, addr: a, wdata: d};
        if (lo) loc_req = r;
        else net_req = r;
        @(posedge clock);
        #1;
        if (lo) loc_req = '0;
        else net_req = '0;
        for (int n = 0; n < 3 && (lo ? loc_ack : net_ack) !== 1'b1; n++) @(posedge clock) #1;
        cmp(lo ? loc_ack : net_ack, 1);
        cmp(lo ? loc_blocked : net_blocked, eb);
        if (!we && !eb) cmp(lo ? loc_rdata : net_rdata, er);
        // Idle edge so the next request is not raised in the step that cleared this one
        @(posedge clock) #1;
    endtask

    task automatic send(input logic [1:0] p, input logic [7:0] n);
        port = p;
        len = n;
        go = 1;
        t0 = sys_time;
        for (int i = 0; i < 100 && busy !== 1'b1; i++) @(posedge clock);
        #1 go = 0;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clock);
        repeat (20) @(posedge clock);
        #1;
    endtask

    task automatic t_misc();
        time_load = 64'h0000_0000_0000_1000;
        time_set = 1;
        @(posedge clock);
        #1 time_set = 0;
        cmp(sys_time, 64'h1000);
        repeat (5) @(posedge clock);
        #1 cmp(sys_time, 64'h1000 + 5 * fbsc_pkg::TIME_STEP);
        repeat (60) @(posedge clock);
        #1 cmp(safe_state, 1);
        cmp(led_err, 1);
        app_run = 1;
        repeat (2) @(posedge clock);
        #1 cmp(led_run, 1);
        $display("misc done");
    endtask

    task automatic t_mem();
        acc(0, 1, 0, 'h0040, 'h3C, 0, 0);
        acc(1, 0, 0, 'h0040, 0, 'h3C, 0);
        acc(1, 1, 0, 'h1FFF, 'hE7, 0, 0);
        acc(0, 0, 0, 'h1FFF, 0, 'hE7, 0);
        // Both sides at once: the network side wins the cycle
        net_req = '{req: 1'b1, we: 1'b1, logical: 1'b0, addr: 'h50, wdata: 'hC3};
        loc_req = '{req: 1'b1, we: 1'b0, logical: 1'b0, addr: 'h50, wdata: 'h00};
        @(posedge clock);
        #1 net_req = '0;
        cmp({net_ack, loc_ack}, 2'b10);
        @(posedge clock);
        #1 loc_req = '0;
        cmp({loc_ack, loc_rdata}, {1'b1, 8'hC3});
        $display("mem done");
    endtask

    task automatic t_sync();
        sb_cfg[0] = '{en: 1'b1, net_writes: 1'b1, mode: fbsc_pkg::FBSC_MAILBOX, start: 'h200, len: 'h2};
        sb_cfg[1] = '{en: 1'b1, net_writes: 1'b1, mode: fbsc_pkg::FBSC_BUFFERED, start: 'h300, len: 'h1};
        @(posedge clock) #1;
        acc(0, 1, 0, 'h200, 'h11, 0, 0);
        acc(0, 1, 0, 'h201, 'h22, 0, 0);
        repeat (2) @(posedge clock) #1;
        cmp({ev_l[0], ev_n[0]}, 2'h2);
        acc(0, 1, 0, 'h200, 'h33, 0, 1);
        acc(1, 1, 0, 'h200, 'h44, 0, 1);
        acc(1, 0, 0, 'h200, 0, 'h11, 0);
        acc(1, 0, 0, 'h201, 0, 'h22, 0);
        repeat (2) @(posedge clock) #1;
        cmp(ev_n[0], 1);
        acc(1, 0, 0, 'h200, 0, 0, 1);
        acc(0, 1, 0, 'h300, 'hA1, 0, 0);
        acc(0, 1, 0, 'h300, 'hB2, 0, 0);
        acc(1, 0, 0, 'h300, 0, 'hB2, 0);
        cmp({safe_state, led_err}, 2'h0);
        lm_cfg[0] = '{en: 1, rd_en: 1, wr_en: 1, lstart: 'h10000, len: 'h4, sbit: 4, ebit: 7, pstart: 'h100};
        acc(0, 1, 1, 'h10001, 'h5A, 0, 0);
        acc(1, 0, 0, 'h0101, 0, 'h5A, 0);
        acc(0, 0, 1, 'h10001, 0, 'h5A, 0);
        acc(1, 1, 0, 'h0100, 'h00, 0, 0);
        acc(0, 1, 1, 'h10000, 'hFF, 0, 0);
        acc(1, 0, 0, 'h0100, 0, 'hF0, 0);
        acc(0, 1, 1, 'h20000, 'h01, 0, 1);
        $display("sync done");
    endtask

    task automatic t_link();
        tx1_n = 0;
        fpu_n = 0;
        enh_link_en = 1;
        send(0, 8'h40);
        cmp(tx1_n, 64);
        cmp(fpu_n, 1);
        cmp(err_cnt[0], 0);
        cmp(an_n, 0);
        cmp(led_act, 3'h1);
        cmp(rx_ts[0] >= t0 && rx_ts[0] <= t0 + 64'd200, 1);
        send(0, 8'h0A);
        cmp(err_cnt[0], 1);
        cmp(an_n, 1);
        cmp(tx1_n, 74);
        loop_closed = 3'b010;
        repeat (10) @(posedge clock) #1;
        tx1_n = 0;
        tx2_n = 0;
        send(0, 8'h40);
        cmp({tx1_n[7:0], tx2_n[7:0]}, 16'h0040);
        loop_closed = 3'b000;
        link_up = 3'b101;
        tx2_n = 0;
        send(0, 8'h40);
        cmp({tx1_n[7:0], tx2_n[7:0]}, 16'h0040);
        cmp({link_state, led_link}, 6'b101101);
        $display("link done");
    endtask

    task automatic print_verdict();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock);
        #1 rst = 0;
        t_misc();
        t_mem();
        t_sync();
        t_link();
        print_verdict();
    end

    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule
